// >>> dv/mcu8_exec_tb.sv
// Self-checking testbench for the instruction execution core.
`timescale 1ns/1ps
`include "mcu8_exec_defines.svh"

module mcu8_exec_tb;
  import mcu8_exec_pkg::*;

  logic               clk;
  logic               rst_b;
  logic [`PC_W-1:0]   prog_addr;
  logic [`IR_W-1:0]   prog_data;
  logic [`DM_AW-1:0]  data_addr;
  logic [7:0]         data_rdata;
  logic [7:0]         data_wdata;
  logic               data_we;
  logic [7:0]         acc;
  logic               carry;
  logic               zero;
  logic [`TBL_HI_W-1:0] table_high;
  logic               instr_done;
  logic               halted;
  logic               wdt_clear;
  logic               wake;
  phase_type          phase;
  logic [`IR_W-1:0]   prog [0:2047];
  logic [7:0]         dmem [0:127];
  int                 num_errors;
  int                 total_checks;
  int                 cyc = 0;
  int                 last_cyc;

  mcu8_exec i_mcu8_exec (
    .CLK        (clk),
    .RST_B      (rst_b),
    .PROG_ADDR  (prog_addr),
    .PROG_DATA  (prog_data),
    .DATA_ADDR  (data_addr),
    .DATA_RDATA (data_rdata),
    .DATA_WDATA (data_wdata),
    .DATA_WE    (data_we),
    .ACC        (acc),
    .CARRY      (carry),
    .ZERO       (zero),
    .TABLE_HIGH (table_high),
    .INSTR_DONE (instr_done),
    .HALTED     (halted),
    .WDT_CLEAR  (wdt_clear),
    .WAKE       (wake),
    .PHASE      (phase)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, cycle counter and memories answering on the falling edge.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Memories present the addressed words half a clock after the address moves.
  always @(negedge clk) begin
    prog_data  <= prog[prog_addr];
    data_rdata <= dmem[data_addr];
  end

  // The data memory takes a write on the edge that sees the strobe.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rst_b && data_we === 1'b1) begin
      dmem[data_addr] <= data_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  function automatic logic [13:0] enc_mem(input logic [3:0] op, input logic d,
                                          input logic [6:0] m);
    return {`CLS_MEM, op, d, m};
  endfunction

  function automatic logic [13:0] enc_imm(input logic [3:0] op, input logic [7:0] x);
    return {`CLS_IMM, op, x};
  endfunction

  function automatic logic [13:0] enc_bit(input logic [1:0] op, input logic [2:0] b,
                                          input logic [6:0] m);
    return {`CLS_BIT, op, b, m};
  endfunction

  function automatic logic [13:0] enc_br(input logic c, input logic [10:0] t);
    return {`CLS_BR, c, t};
  endfunction

  // Compares one value and counts the outcome.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Checks the accumulator and both flags together.
  task automatic check_alu(input logic [7:0] a, input logic c, input logic z);
    check({8'h00, acc}, {8'h00, a});
    check({15'h0000, carry}, {15'h0000, c});
    check({15'h0000, zero}, {15'h0000, z});
  endtask

  // Clears both memories; start_run then resets the core for 4 clocks.
  task automatic clear_mem();
    for (int i = 0; i < 2048; i++) prog[i] = 14'h0000;
    for (int i = 0; i < 128; i++) dmem[i] = 8'h00;
  endtask

  task automatic start_run();
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
  endtask

  // Waits for the next completion pulse; a nonzero gap is the expected clock count.
  task automatic step(input int gap);
    int n;
    n = 0;
    @(negedge clk);
    while (instr_done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, instr_done}, 16'h0001);
    check({14'h0000, phase}, {14'h0000, PH_FETCH});
    if (gap > 0) check(16'(cyc - last_cyc), 16'(gap));
    last_cyc = cyc;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic arith_logic();
    clear_mem();
    dmem[7'h21] = 8'h3C;
    prog[0] = enc_imm(`IOP_MOV, 8'hF0);
    prog[1] = enc_imm(`IOP_ADD, 8'h20);
    prog[2] = enc_imm(`IOP_SUB, 8'h11);
    prog[3] = enc_imm(`IOP_SUB, 8'hFF);
    prog[4] = enc_imm(`IOP_XOR, 8'h5A);
    prog[5] = enc_imm(`IOP_AND, 8'hA5);
    prog[6] = enc_mem(`OP_MOV, 1'b0, 7'h21);
    prog[7] = enc_mem(`OP_MOV, 1'b1, 7'h20);
    prog[8] = enc_mem(`OP_ADD, 1'b1, 7'h21);
    prog[9] = enc_imm(`IOP_OR, 8'hE0);
    prog[10] = enc_mem(`OP_ADD, 1'b0, 7'h21);
    prog[11] = enc_mem(`OP_ADC, 1'b0, 7'h21);
    prog[12] = enc_imm(`IOP_SUB, 8'hF0);
    prog[13] = enc_mem(`OP_SBC, 1'b0, 7'h21);
    start_run();
    step(0);
    check({8'h00, acc}, 16'h00F0);
    step(4);
    check_alu(8'h10, 1'b1, 1'b0);
    step(4);
    check_alu(8'hFF, 1'b1, 1'b0);
    step(4);
    check_alu(8'h00, 1'b0, 1'b1);
    step(4);
    check_alu(8'h5A, 1'b0, 1'b0);
    step(4);
    check_alu(8'h00, 1'b0, 1'b1);
    step(4);
    check({8'h00, acc}, 16'h003C);
    step(4);
    check({7'h00, data_we, data_wdata}, 16'h013C);
    step(4);
    check({7'h00, data_we, data_wdata}, 16'h0178);
    check({8'h00, acc}, 16'h003C);
    step(4);
    check_alu(8'hFC, 1'b0, 1'b0);
    step(4);
    check_alu(8'h74, 1'b1, 1'b0);
    step(4);
    check_alu(8'hED, 1'b0, 1'b0);
    step(4);
    check_alu(8'hFD, 1'b1, 1'b0);
    step(4);
    check_alu(8'h84, 1'b0, 1'b0);
  endtask

  task automatic modify_ops();
    clear_mem();
    dmem[7'h22] = 8'h81;
    prog[0] = enc_mem(`OP_INC, 1'b0, 7'h22);
    prog[1] = enc_mem(`OP_DEC, 1'b1, 7'h22);
    prog[2] = enc_mem(`OP_ROR, 1'b0, 7'h22);
    prog[3] = enc_mem(`OP_ROLC, 1'b0, 7'h22);
    prog[4] = enc_mem(`OP_RORC, 1'b0, 7'h22);
    prog[5] = enc_mem(`OP_ROL, 1'b1, 7'h22);
    prog[6] = enc_bit(`BOP_SET, 3'h3, 7'h22);
    prog[7] = enc_bit(`BOP_CLR, 3'h0, 7'h22);
    prog[8] = enc_mem(`OP_INVERT, 1'b0, 7'h22);
    prog[9] = enc_mem(`OP_AND, 1'b0, 7'h22);
    start_run();
    step(0);
    check({8'h00, acc}, 16'h0082);
    step(4);
    check({7'h00, data_we, data_wdata}, 16'h0180);
    step(4);
    check({8'h00, acc}, 16'h0040);
    step(4);
    check({7'h00, carry, acc}, 16'h0100);
    step(4);
    check({7'h00, carry, acc}, 16'h00C0);
    step(4);
    check({7'h00, data_we, data_wdata}, 16'h0101);
    step(4);
    check({7'h00, data_we, data_wdata}, 16'h0109);
    step(4);
    check({7'h00, data_we, data_wdata}, 16'h0108);
    step(4);
    check({7'h00, zero, acc}, 16'h00F7);
    step(4);
    check({7'h00, zero, acc}, 16'h0100);
  endtask

  task automatic control_flow();
    clear_mem();
    prog[11'h000] = enc_br(1'b0, 11'h010);
    prog[11'h010] = enc_br(1'b1, 11'h020);
    prog[11'h011] = enc_imm(`IOP_MOV, 8'h00);
    prog[11'h012] = enc_imm(`IOP_SKZ, 8'h23);
    prog[11'h013] = enc_imm(`IOP_MOV, 8'hEE);
    prog[11'h014] = enc_imm(`IOP_MOV, 8'h11);
    prog[11'h015] = enc_bit(`BOP_SKNZ, 3'h0, 7'h23);
    prog[11'h016] = enc_imm(`IOP_MOV, 8'h22);
    prog[11'h017] = enc_mem(`OP_MOV, 1'b1, `PCL_ADDR);
    prog[11'h020] = enc_imm(`IOP_MOV, 8'h77);
    prog[11'h021] = enc_mem(`OP_MISC, 1'b0, `MISC_INTERRUPT_SERVICE_BACK);
    prog[11'h022] = enc_imm(`IOP_MOV, 8'h33);
    start_run();
    step(0);
    step(8);
    step(8);
    check({8'h00, acc}, 16'h0077);
    step(4);
    step(8);
    check({8'h00, acc}, 16'h0000);
    step(4);
    step(8);
    check({8'h00, acc}, 16'h0011);
    step(4);
    step(4);
    check({8'h00, acc}, 16'h0022);
    step(4);
    step(8);
    check({8'h00, acc}, 16'h0033);
  endtask

  task automatic table_halt();
    int n;
    clear_mem();
    dmem[7'h24] = 8'h40;
    prog[0] = enc_imm(`IOP_TABLE, 8'h24);
    prog[1] = enc_mem(`OP_MISC, 1'b0, `MISC_WDT);
    prog[2] = enc_imm(`IOP_TABLE, 8'hA4);
    prog[3] = enc_mem(`OP_MISC, 1'b0, `MISC_HALT);
    prog[4] = enc_imm(`IOP_MOV, 8'h99);
    prog[11'h040] = 14'h2A5C;
    start_run();
    step(0);
    step(8);
    check({15'h0000, wdt_clear}, 16'h0001);
    check({2'h0, table_high, acc}, 16'h2A5C);
    step(4);
    step(8);
    repeat (2) @(negedge clk);
    check({15'h0000, halted}, 16'h0001);
    n = 0;
    repeat (20) begin
      @(negedge clk);
      if (instr_done !== 1'b0) n++;
    end
    check(16'(n), 16'h0000);
    check({8'h00, dmem[7'h24]}, 16'h005C);
    wake = 1'b1;
    step(0);
    check({7'h00, halted, acc}, 16'h0099);
    wake = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, watchdog and main sequence.
  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cuts a hang short well after the expected run of a few hundred clocks.
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end

  initial begin
    rst_b = 1'b0;
    wake = 1'b0;
    num_errors = 0;
    total_checks = 0;
    last_cyc = 0;
    arith_logic();
    modify_ops();
    control_flow();
    table_halt();
    wrap_up();
  end

endmodule

// >>> pkg/mcu8_exec_defines.svh
// Constants for the instruction execution core: widths, encodings and addresses.
`ifndef MCU8_EXEC_DEFINES_SVH
`define MCU8_EXEC_DEFINES_SVH

// Bus widths.
`define PC_W            11
`define IR_W            14
`define DM_AW           7
`define TBL_HI_W        6

// System clocks per instruction cycle.
`define CLKS_PER_ICYCLE 4

// Instruction classes held in bits 13:12.
`define CLS_MEM         2'h0
`define CLS_IMM         2'h1
`define CLS_BIT         2'h2
`define CLS_BR          2'h3

// Memory operand operations held in bits 11:8; bit 7 set writes memory.
`define OP_MISC         4'h0
`define OP_MOV          4'h1
`define OP_ADD          4'h2
`define OP_ADC          4'h3
`define OP_SUB          4'h4
`define OP_SBC          4'h5
`define OP_AND          4'h6
`define OP_OR           4'h7
`define OP_XOR          4'h8
`define OP_INVERT       4'h9
`define OP_INC          4'hA
`define OP_DEC          4'hB
`define OP_ROR          4'hC
`define OP_ROL          4'hD
`define OP_RORC         4'hE
`define OP_ROLC         4'hF

// Immediate and special operations in the immediate class.
`define IOP_MOV         4'h0
`define IOP_ADD         4'h1
`define IOP_SUB         4'h2
`define IOP_AND         4'h3
`define IOP_OR          4'h4
`define IOP_XOR         4'h5
`define IOP_SKZ         4'h8
`define IOP_TABLE       4'h9

// Miscellaneous codes held in the operand field of the misc operation.
`define MISC_NOP        7'h00
`define MISC_RET        7'h01
`define MISC_INTERRUPT_SERVICE_BACK       7'h02
`define MISC_HALT       7'h03
`define MISC_WDT        7'h04

// Bit operations held in bits 11:10.
`define BOP_CLR         2'h0
`define BOP_SET         2'h1
`define BOP_SKZ         2'h2
`define BOP_SKNZ        2'h3

// Data memory address of the program counter low byte.
`define PCL_ADDR        7'h06

`endif

// >>> pkg/mcu8_exec_pkg.sv
// Types shared by the instruction execution core.
package mcu8_exec_pkg;

  // Four system clocks of one instruction cycle.
  typedef enum logic [1:0] {PH_FETCH, PH_DECODE, PH_OPERAND, PH_EXEC} phase_type;

endpackage

// >>> rtl/mcu8_exec.sv
// Instruction execution and timing control of an 8-bit accumulator core.
//
// Overview of operation
// - Most instructions one cycle; branch, call, table two.
// - One instruction cycle is four system clocks.
// - Writing program counter low byte costs one extra cycle.
// - Taken skip costs one extra cycle.
// - Carry reports add overflow and subtract borrow.
// - Increment and decrement change operand by one.
// - Logical results of zero set the zero flag.
// - Rotates shift exactly one bit position.
// - Through-carry rotates move the lost bit into carry.
// - Call saves next address; return resumes there.
// - Jump loads target and saves no return.
// - Conditional branches test byte or bit, maybe skip.
// - Bit set and clear touch only one bit.
// - Three move forms to and from accumulator.
// - Table read fetches constants from program memory.
// - Two-operand operations route through the accumulator.
// - Halt instruction and watchdog service instruction exist.
`timescale 1ns/1ps
`include "mcu8_exec_defines.svh"

module mcu8_exec #(
  parameter int STACK_DEPTH = 4
) (
  input  wire logic                          CLK,
  input  wire logic                          RST_B,
  output logic [`PC_W-1:0]                   PROG_ADDR,
  input  wire logic [`IR_W-1:0]              PROG_DATA,
  output logic [`DM_AW-1:0]                  DATA_ADDR,
  input  wire logic [7:0]                    DATA_RDATA,
  output logic [7:0]                         DATA_WDATA,
  output logic                               DATA_WE,
  output logic [7:0]                         ACC,
  output logic                               CARRY,
  output logic                               ZERO,
  output logic [`TBL_HI_W-1:0]               TABLE_HIGH,
  output logic                               INSTR_DONE,
  output logic                               HALTED,
  output logic                               WDT_CLEAR,
  input  wire logic                          WAKE,
  output mcu8_exec_pkg::phase_type           PHASE
);
  import mcu8_exec_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);

  // Assertions below sample on the rising clock and pause while in reset.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // The stack pointer wraps, so the depth must be a power of two of at least two.
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin
    $error("STACK_DEPTH must be a power of two of at least two.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.
  phase_type             phase_reg;
  logic [`PC_W-1:0]      pc_reg;
  logic [`IR_W-1:0]      ir_reg;
  logic [`IR_W-1:0]      tab_reg;
  logic [7:0]            operand_reg;
  logic                  bubble_reg;
  logic                  tab_pend_reg;
  logic                  halted_reg;
  logic [SP_W-1:0]       sp_reg;
  logic [`PC_W-1:0]      stack_mem [STACK_DEPTH];
  logic [2:0]            wake_sync_reg;

  // Add with carry in; bit 8 is the carry out.
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  // Subtract with borrow in; bit 8 is set when the result falls below zero.
  function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b,
                                      input logic bin);
    sub9 = {1'b0, a} - {1'b0, b} - {8'h00, bin};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Instruction field decode.
  wire logic [1:0]       cls       = ir_reg[13:12];
  wire logic [3:0]       op        = ir_reg[11:8];
  wire logic             dst_mem   = ir_reg[7];
  wire logic [6:0]       m_field   = ir_reg[6:0];
  wire logic [7:0]       imm       = ir_reg[7:0];
  wire logic [1:0]       bop       = ir_reg[11:10];
  wire logic [2:0]       bit_idx   = ir_reg[9:7];
  wire logic [7:0]       bit_mask  = 8'h01 << bit_idx;
  wire logic [`PC_W-1:0] stack_top = stack_mem[SP_W'(sp_reg - 1'b1)];
  wire logic [`PC_W-1:0] cur_pc    = pc_reg - `PC_W'(1);
  wire logic             exec      = phase_reg == PH_EXEC && !bubble_reg && !halted_reg;
  wire logic             wake_ok   = wake_sync_reg[1] && wake_sync_reg[2];

  logic [7:0] alu_res;
  logic       alu_c;
  logic       upd_c;
  logic       upd_z;
  logic       to_acc;
  logic       to_mem;
  logic       do_skip;
  logic       do_jump;
  logic       do_call;
  logic       do_ret;
  logic       do_halt;
  logic       do_wdt;
  logic       do_tab;
  logic [8:0] arith;

  // Operation select: bit operations and single-operand operations with bit 7 set bypass the accumulator.
  always_comb begin
    alu_res = operand_reg;
    alu_c   = CARRY;
    upd_c   = 1'b0;
    upd_z   = 1'b0;
    to_acc  = 1'b0;
    to_mem  = 1'b0;
    do_skip = 1'b0;
    do_jump = 1'b0;
    do_call = 1'b0;
    do_ret  = 1'b0;
    do_halt = 1'b0;
    do_wdt  = 1'b0;
    do_tab  = 1'b0;
    arith   = 9'h000;
    case (cls)
      `CLS_MEM: begin
        to_acc = !dst_mem;
        to_mem = dst_mem;
        case (op)
          `OP_MISC: begin
            to_acc  = 1'b0;
            to_mem  = 1'b0;
            do_ret  = m_field == `MISC_RET || m_field == `MISC_INTERRUPT_SERVICE_BACK;
            do_halt = m_field == `MISC_HALT;
            do_wdt  = m_field == `MISC_WDT;
          end
          `OP_MOV:    alu_res = dst_mem ? ACC : operand_reg;
          `OP_ADD, `OP_ADC, `OP_SUB, `OP_SBC: begin
            if (op == `OP_ADD || op == `OP_ADC) begin
              arith = add9(ACC, operand_reg, op == `OP_ADC && CARRY);
            end else begin
              arith = sub9(ACC, operand_reg, op == `OP_SBC && CARRY);
            end
            alu_res = arith[7:0];
            alu_c   = arith[8];
            upd_c   = 1'b1;
            upd_z   = 1'b1;
          end
          `OP_AND:    begin alu_res = ACC & operand_reg; upd_z = 1'b1; end
          `OP_OR:     begin alu_res = ACC | operand_reg; upd_z = 1'b1; end
          `OP_XOR:    begin alu_res = ACC ^ operand_reg; upd_z = 1'b1; end
          `OP_INVERT: begin alu_res = ~operand_reg; upd_z = 1'b1; end
          `OP_INC:    begin alu_res = operand_reg + 8'h01; upd_z = 1'b1; end
          `OP_DEC:    begin alu_res = operand_reg - 8'h01; upd_z = 1'b1; end
          `OP_ROR:    alu_res = {operand_reg[0], operand_reg[7:1]};
          `OP_ROL:    alu_res = {operand_reg[6:0], operand_reg[7]};
          `OP_RORC: begin
            alu_res = {CARRY, operand_reg[7:1]};
            alu_c   = operand_reg[0];
            upd_c   = 1'b1;
          end
          default: begin
            alu_res = {operand_reg[6:0], CARRY};
            alu_c   = operand_reg[7];
            upd_c   = 1'b1;
          end
        endcase
      end
      `CLS_IMM: begin
        to_acc = 1'b1;
        case (op)
          `IOP_MOV: alu_res = imm;
          `IOP_ADD, `IOP_SUB: begin
            arith   = (op == `IOP_ADD) ? add9(ACC, imm, 1'b0) : sub9(ACC, imm, 1'b0);
            alu_res = arith[7:0];
            alu_c   = arith[8];
            upd_c   = 1'b1;
            upd_z   = 1'b1;
          end
          `IOP_AND: begin alu_res = ACC & imm; upd_z = 1'b1; end
          `IOP_OR:  begin alu_res = ACC | imm; upd_z = 1'b1; end
          `IOP_XOR: begin alu_res = ACC ^ imm; upd_z = 1'b1; end
          `IOP_SKZ: begin
            to_acc  = dst_mem;
            do_skip = operand_reg == 8'h00;
          end
          `IOP_TABLE: begin
            to_acc = 1'b0;
            do_tab = 1'b1;
          end
          default: to_acc = 1'b0;
        endcase
      end
      `CLS_BIT: begin
        to_mem = bop == `BOP_CLR || bop == `BOP_SET;
        alu_res = (bop == `BOP_SET) ? (operand_reg | bit_mask)
                                    : (operand_reg & ~bit_mask);
        do_skip = (bop == `BOP_SKZ && !(|(operand_reg & bit_mask)))
               || (bop == `BOP_SKNZ && |(operand_reg & bit_mask));
      end
      default: begin
        do_jump = 1'b1;
        do_call = ir_reg[11];
      end
    endcase
  end

  // Control transfer decode and the next program counter.
  wire logic pcl_write = to_mem && m_field == `PCL_ADDR;
  wire logic two_cycle = do_skip || do_jump || do_ret || do_tab || pcl_write;
  wire logic [`PC_W-1:0] pc_next =
      do_jump   ? ir_reg[10:0] :
      do_ret    ? stack_top :
      pcl_write ? {pc_reg[10:8], alu_res} :
      do_skip   ? pc_reg + `PC_W'(1) : pc_reg;
  wire logic tab_to_acc = !ir_reg[7];

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencer; it runs on every clock, halted or not.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      phase_reg <= PH_FETCH;
    end else begin
      phase_reg <= phase_type'(phase_reg + 2'h1);
    end
  end

  // Wake input passes three flops; it counts only while the last two are both high.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wake_sync_reg <= 3'h0;
    end else begin
      wake_sync_reg <= {wake_sync_reg[1:0], WAKE};
    end
  end

  // Fetch and operand read; a bubble cycle keeps the program counter still.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pc_reg      <= `PC_W'(0);
      ir_reg      <= `IR_W'(0);
      tab_reg     <= `IR_W'(0);
      operand_reg <= 8'h00;
      DATA_ADDR   <= `DM_AW'(0);
    end else if (phase_reg == PH_FETCH && !halted_reg) begin
      if (bubble_reg) begin
        tab_reg <= PROG_DATA;
      end else begin
        ir_reg    <= PROG_DATA;
        DATA_ADDR <= PROG_DATA[6:0];
        pc_reg    <= pc_reg + `PC_W'(1);
      end
    end else if (phase_reg == PH_DECODE && !bubble_reg) begin
      operand_reg <= (DATA_ADDR == `PCL_ADDR) ? cur_pc[7:0] : DATA_RDATA;
    end else if (exec) begin
      pc_reg <= pc_next;
    end
  end

  // Return address stack; a call pushes the following address.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sp_reg <= SP_W'(0);
    end else if (exec && do_call) begin
      stack_mem[sp_reg] <= pc_reg;
      sp_reg            <= SP_W'(sp_reg + 1'b1);
    end else if (exec && do_ret) begin
      sp_reg <= SP_W'(sp_reg - 1'b1);
    end
  end

  // Execution: results, flags, write strobe, fetch address and bubble.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ACC          <= 8'h00;
      CARRY        <= 1'b0;
      ZERO         <= 1'b0;
      DATA_WE      <= 1'b0;
      DATA_WDATA   <= 8'h00;
      PROG_ADDR    <= `PC_W'(0);
      TABLE_HIGH   <= `TBL_HI_W'(0);
      INSTR_DONE   <= 1'b0;
      WDT_CLEAR    <= 1'b0;
      bubble_reg   <= 1'b0;
      tab_pend_reg <= 1'b0;
      halted_reg   <= 1'b0;
    end else begin
      DATA_WE    <= 1'b0;
      INSTR_DONE <= 1'b0;
      WDT_CLEAR  <= 1'b0;
      if (exec) begin
        if (to_acc) ACC <= alu_res;
        if (upd_c) CARRY <= alu_c;
        if (upd_z) ZERO <= alu_res == 8'h00;
        DATA_WE      <= to_mem;
        DATA_WDATA   <= alu_res;
        PROG_ADDR    <= do_tab ? {pc_reg[10:8], operand_reg} : pc_next;
        bubble_reg   <= two_cycle;
        tab_pend_reg <= do_tab;
        halted_reg   <= do_halt;
        WDT_CLEAR    <= do_wdt;
        INSTR_DONE   <= 1'b1;
      end else if (phase_reg == PH_EXEC && bubble_reg) begin
        bubble_reg   <= 1'b0;
        tab_pend_reg <= 1'b0;
        PROG_ADDR    <= pc_reg;
        if (tab_pend_reg) begin
          TABLE_HIGH <= tab_reg[13:8];
          if (tab_to_acc) ACC <= tab_reg[7:0];
          DATA_WE    <= !tab_to_acc;
          DATA_WDATA <= tab_reg[7:0];
        end
      end else if (phase_reg == PH_EXEC && halted_reg && wake_ok) begin
        halted_reg <= 1'b0;
      end
    end
  end

  assign HALTED = halted_reg;
  assign PHASE  = phase_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on timing, flags and control flow.
  wire logic       add_ovf  = ({1'b0, ACC} + {1'b0, operand_reg}) > 9'h0FF;
  wire logic       is_add   = cls == `CLS_MEM && op == `OP_ADD && !dst_mem;
  wire logic       is_logic = cls == `CLS_MEM && !dst_mem
                              && (op == `OP_AND || op == `OP_OR || op == `OP_XOR);

  sequence one_cycle_gap;
    INSTR_DONE ##1 !INSTR_DONE [*3] ##1 INSTR_DONE;
  endsequence

  sequence two_cycle_gap;
    INSTR_DONE ##1 !INSTR_DONE [*7];
  endsequence

  a_single_cycle: assert property (exec && !two_cycle && !do_halt |=> one_cycle_gap)
    else $error("Single-cycle instruction did not complete four clocks later.");
  a_done_spacing: assert property (INSTR_DONE |=> !INSTR_DONE [*3])
    else $error("Instructions completed closer than four clocks apart.");
  a_branch_delay: assert property (exec && (do_jump || do_ret || do_tab) |=> two_cycle_gap)
    else $error("Branch, return or table read did not take two cycles.");
  a_pcl_write_cost: assert property (exec && pcl_write |=> two_cycle_gap)
    else $error("Write to the program counter low byte lacked its extra cycle.");
  a_skip_cost: assert property (exec && do_skip |=> two_cycle_gap)
    else $error("Taken skip did not cost an extra cycle.");
  a_add_carry: assert property (exec && is_add |=> CARRY == $past(add_ovf))
    else $error("Carry does not match add overflow.");
  a_inc_by_one: assert property (exec && cls == `CLS_MEM && op == `OP_INC && !dst_mem
                                 |=> ACC == 8'($past(operand_reg) + 8'h01))
    else $error("Increment did not add exactly one.");
  a_logic_zero: assert property (exec && is_logic |=> ZERO == (ACC == 8'h00))
    else $error("Zero flag disagrees with logical result.");
  a_jump_target: assert property (exec && do_jump && !do_call
                                  |=> pc_reg == $past(ir_reg[10:0]) && $stable(sp_reg))
    else $error("Jump target wrong or return address saved.");
  a_call_return: assert property (exec && do_call
                                  |=> stack_top == $past(pc_reg))
    else $error("Call did not save the following address.");
  a_bit_only: assert property (exec && cls == `CLS_BIT && to_mem
                               |=> DATA_WE && ((DATA_WDATA ^ $past(operand_reg))
                                               & ~$past(bit_mask)) == 8'h00)
    else $error("Bit operation changed other bits.");

endmodule
